// File: hdl/encoder_interrupt_regs.sv
// Encoder position counter, timer, interrupt flag and register file behind classic Wishbone
//
// How it works
// - Counter rollover or underflow raises an event.
// - Qualified index or count error raises event.
// - Timer period match raises event, both directions.
// - Any event sets the single sticky flag.
// - Only software clears the flag.
// - Request forwarded only while enable bit set.
// - Control has swap, pin, gate, prescale fields.
// - Control register resets to all zeros.
// - Unimplemented bits read zero, writes ignored.
// - Index modes flag count error at limits.
// - Disable bit blocks count error interrupt only.
// - Timer uses position as count, maximum period.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
module encoder_interrupt_regs #(
  parameter int ADDR_WIDTH = 12
) (
  // System
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [ADDR_WIDTH-1:0]  adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  // Encoder pins
  input  wire logic                   phase_a_i,
  input  wire logic                   phase_b_i,
  input  wire logic                   index_i,
  // Direction pin
  output logic                        dir_pin_o,
  output logic                        dir_pin_en_o,
  // Interrupt request
  output logic                        irq_o
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_WIDTH < encoder_pkg::MIN_ADDR_WIDTH) begin : g_bad_width
    $error("ADDR_WIDTH too small for the register map");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic        ack_r;
  logic [31:0] dat_r;
  logic        count_error_flag_r;
  logic        idle_stop_r;
  logic        dir_r;
  logic [2:0]  mode_r;
  logic        phase_swap_r;
  logic        direction_pin_output_r;
  logic        timer_gate_enable_r;
  logic [1:0]  timer_prescale_select_r;
  logic        index_reset_enable_r;
  logic        timer_clock_source_r;
  logic        direction_source_select_r;
  logic [1:0]  index_match_r;
  logic        count_error_irq_disable_r;
  logic        filter_output_enable_r;
  logic [2:0]  filter_clock_div_r;
  logic [15:0] position_count_r;
  logic [15:0] maximum_count_r;
  logic        encoder_irq_flag_r;
  logic        encoder_irq_enable_r;
  logic        irq_r;
  logic        dir_pin_r;
  logic        dir_pin_en_r;
  logic [7:0]  presc_cnt_r;
  logic [15:0] position_count_nxt;
  logic        roll_evt;
  logic        period_evt;
  logic        count_err_set;

  encoder_pkg::qdec_out_type dec;

  quad_decoder u_decoder (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .phase_a_i    (phase_a_i),
    .phase_b_i    (phase_b_i),
    .index_i      (index_i),
    .phase_swap_i (phase_swap_r),
    .dec_o        (dec)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [7:0] presc_tc(input logic [1:0] code);
    case (code)
      2'h0:    presc_tc = encoder_pkg::PRESC_TC_1;
      2'h1:    presc_tc = encoder_pkg::PRESC_TC_8;
      2'h2:    presc_tc = encoder_pkg::PRESC_TC_64;
      default: presc_tc = encoder_pkg::PRESC_TC_256;
    endcase
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic       req       = cyc_i & stb_i;
  wire logic       commit    = req & we_i & ack_r;
  wire logic [9:0] word_idx  = 10'(adr_i[ADDR_WIDTH-1:2]);
  wire logic       hit_ctl   = word_idx == encoder_pkg::IDX_CONTROL;
  wire logic       hit_flt   = word_idx == encoder_pkg::IDX_FILTER;
  wire logic       hit_pos   = word_idx == encoder_pkg::IDX_POSITION;
  wire logic       hit_max   = word_idx == encoder_pkg::IDX_MAXIMUM;
  wire logic       hit_flag  = word_idx == encoder_pkg::IDX_IRQ_FLAG;
  wire logic       hit_en    = word_idx == encoder_pkg::IDX_IRQ_ENABLE;
  wire logic       wr_ctl    = commit & hit_ctl;
  wire logic       wr_flt    = commit & hit_flt;
  wire logic       wr_pos    = commit & hit_pos;
  wire logic       wr_max    = commit & hit_max;
  wire logic       wr_flag   = commit & hit_flag & sel_i[0];
  wire logic       wr_en     = commit & hit_en & sel_i[0];

  // Unimplemented positions are constant zero here, so reads return zero
  wire logic [15:0] ctl_view = {count_error_flag_r, 1'b0, idle_stop_r, dec.idx, dir_r, mode_r,
                                phase_swap_r, direction_pin_output_r, timer_gate_enable_r,
                                timer_prescale_select_r, index_reset_enable_r,
                                timer_clock_source_r, direction_source_select_r};
  wire logic [15:0] flt_view = {5'h00, index_match_r, count_error_irq_disable_r,
                                filter_output_enable_r, filter_clock_div_r, 4'h0};
  wire logic [15:0] ctl_w = merge16(ctl_view, dat_i[15:0], sel_i[1:0]);
  wire logic [15:0] flt_w = merge16(flt_view, dat_i[15:0], sel_i[1:0]);
  wire logic [15:0] pos_w = merge16(position_count_r, dat_i[15:0], sel_i[1:0]);
  wire logic [15:0] max_w = merge16(maximum_count_r, dat_i[15:0], sel_i[1:0]);

  wire logic [15:0] rd_data = hit_ctl  ? ctl_view :
                              hit_flt  ? flt_view :
                              hit_pos  ? position_count_r :
                              hit_max  ? maximum_count_r :
                              hit_flag ? {15'h0000, encoder_irq_flag_r} :
                              hit_en   ? {15'h0000, encoder_irq_enable_r} :
                              16'h0000;

  // ****************************************
  // Counting sources
  // ****************************************
  wire logic mode_qei    = mode_r[2];
  wire logic mode_x4     = mode_r[1];
  wire logic index_mode  = ~mode_r[0];
  wire logic mode_timer  = mode_r == encoder_pkg::MODE_TIMER;
  wire logic qei_step    = mode_qei & (mode_x4 ? (dec.a_edge | dec.b_edge) : dec.a_edge);
  wire logic presc_done  = presc_cnt_r == presc_tc(timer_prescale_select_r);
  // Gated accumulation only counts internal ticks while phase A is high
  wire logic gate_open   = ~timer_gate_enable_r | dec.a;
  wire logic timer_tick  = mode_timer & (timer_clock_source_r ? dec.a_rise
                                                               : (presc_done & gate_open));
  wire logic timer_up    = direction_source_select_r ? dec.b : dir_r;
  wire logic index_evt   = mode_qei & index_mode & dec.index_pulse;
  wire logic gate_evt    = mode_timer & timer_gate_enable_r & ~timer_clock_source_r
                           & dec.a_fall;
  wire logic [15:0] max_plus_one = 16'(maximum_count_r + encoder_pkg::ONE);

  // ****************************************
  // Position counter and timer
  // ****************************************
  always_comb begin
    position_count_nxt = position_count_r;
    roll_evt           = 1'b0;
    period_evt         = 1'b0;
    count_err_set      = 1'b0;
    if (qei_step) begin
      if (dec.up) begin
        if (!index_mode && position_count_r == maximum_count_r) begin
          position_count_nxt = 16'h0000;
          roll_evt           = 1'b1;
        end else begin
          position_count_nxt = 16'(position_count_r + encoder_pkg::ONE);
        end
        count_err_set = index_mode && position_count_nxt == max_plus_one;
      end else begin
        if (!index_mode && position_count_r == 16'h0000) begin
          position_count_nxt = maximum_count_r;
          roll_evt           = 1'b1;
        end else begin
          position_count_nxt = 16'(position_count_r - encoder_pkg::ONE);
        end
        count_err_set = index_mode && position_count_nxt == encoder_pkg::ALL_ONES;
      end
    end else if (timer_tick) begin
      if (timer_up) begin
        if (position_count_r == maximum_count_r) begin
          position_count_nxt = 16'h0000;
          period_evt         = 1'b1;
        end else begin
          position_count_nxt = 16'(position_count_r + encoder_pkg::ONE);
        end
      end else begin
        if (position_count_r == 16'h0000) begin
          position_count_nxt = maximum_count_r;
          period_evt         = 1'b1;
        end else begin
          position_count_nxt = 16'(position_count_r - encoder_pkg::ONE);
        end
      end
    end
    if (index_evt && index_reset_enable_r) begin
      position_count_nxt = 16'h0000;
    end
    // Software write wins over counting in the same cycle
    if (wr_pos) begin
      position_count_nxt = pos_w;
    end
  end

  // ****************************************
  // Event merge
  // ****************************************
  // Count error still sets its flag while its interrupt is disabled
  wire logic err_evt   = count_err_set & ~count_error_irq_disable_r;
  wire logic any_evt   = roll_evt | index_evt | err_evt | period_evt | gate_evt;
  wire logic flag_kept = wr_flag ? dat_i[encoder_pkg::IRQ_BIT] : encoder_irq_flag_r;
  wire logic flag_nxt  = flag_kept | any_evt;
  wire logic cerr_kept = wr_ctl ? ctl_w[encoder_pkg::CTL_COUNT_ERROR] : count_error_flag_r;
  wire logic dir_nxt   = qei_step ? dec.up :
                         (wr_ctl && mode_timer) ? ctl_w[encoder_pkg::CTL_DIRECTION] : dir_r;

  // ****************************************
  // Bus response
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      dat_r <= {16'h0000, rd_data};
    end
  end

  // ****************************************
  // Control and filter registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {count_error_flag_r, idle_stop_r, dir_r, mode_r, phase_swap_r, direction_pin_output_r,
       timer_gate_enable_r, timer_prescale_select_r, index_reset_enable_r,
       timer_clock_source_r, direction_source_select_r} <= 14'h0000;
      {index_match_r, count_error_irq_disable_r, filter_output_enable_r,
       filter_clock_div_r} <= 7'h00;
    end else begin
      count_error_flag_r <= cerr_kept | count_err_set;
      dir_r              <= dir_nxt;
      if (wr_ctl) begin
        idle_stop_r               <= ctl_w[encoder_pkg::CTL_IDLE_STOP];
        mode_r                    <= ctl_w[encoder_pkg::CTL_MODE_LSB +: 3];
        phase_swap_r              <= ctl_w[encoder_pkg::CTL_PHASE_SWAP];
        direction_pin_output_r    <= ctl_w[encoder_pkg::CTL_DIR_PIN_OUT];
        timer_gate_enable_r       <= ctl_w[encoder_pkg::CTL_TIMER_GATE];
        timer_prescale_select_r   <= ctl_w[encoder_pkg::CTL_PRESCALE_LSB +: 2];
        index_reset_enable_r      <= ctl_w[encoder_pkg::CTL_INDEX_RESET];
        timer_clock_source_r      <= ctl_w[encoder_pkg::CTL_TIMER_CLOCK];
        direction_source_select_r <= ctl_w[encoder_pkg::CTL_DIR_SOURCE];
      end
      if (wr_flt) begin
        index_match_r             <= flt_w[encoder_pkg::FLT_MATCH_LSB +: 2];
        count_error_irq_disable_r <= flt_w[encoder_pkg::FLT_CERR_IRQ_DIS];
        filter_output_enable_r    <= flt_w[encoder_pkg::FLT_OUTPUT_ENABLE];
        filter_clock_div_r        <= flt_w[encoder_pkg::FLT_CLOCK_DIV_LSB +: 3];
      end
    end
  end

  // ****************************************
  // Counter, period and prescaler
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_count_r <= encoder_pkg::RST_POSITION;
      maximum_count_r  <= encoder_pkg::RST_MAXIMUM;
      presc_cnt_r      <= 8'h00;
    end else begin
      position_count_r <= position_count_nxt;
      if (wr_max) begin
        maximum_count_r <= max_w;
      end
      // Control writes restart the prescaler so a new ratio takes effect cleanly
      if (!mode_timer || timer_clock_source_r || presc_done || wr_ctl) begin
        presc_cnt_r <= 8'h00;
      end else if (gate_open) begin
        presc_cnt_r <= 8'(presc_cnt_r + 8'h01);
      end
    end
  end

  // ****************************************
  // Interrupt flag, enable and outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      encoder_irq_flag_r   <= 1'b0;
      encoder_irq_enable_r <= 1'b0;
      irq_r                <= 1'b0;
      dir_pin_r            <= 1'b0;
      dir_pin_en_r         <= 1'b0;
    end else begin
      encoder_irq_flag_r <= flag_nxt;
      if (wr_en) begin
        encoder_irq_enable_r <= dat_i[encoder_pkg::IRQ_BIT];
      end
      irq_r        <= encoder_irq_flag_r & encoder_irq_enable_r;
      dir_pin_r    <= dir_r;
      dir_pin_en_r <= direction_pin_output_r;
    end
  end

  assign dat_o        = dat_r;
  assign ack_o        = ack_r;
  assign irq_o        = irq_r;
  assign dir_pin_o    = dir_pin_r;
  assign dir_pin_en_o = dir_pin_en_r;

endmodule

// File: hdl/encoder_pkg.sv
// Constants, register layout and carrier types for the encoder interrupt and register block
package encoder_pkg;

  // ****************************************
  // Register indices (byte address is index times four)
  // ****************************************
  localparam logic [9:0] IDX_CONTROL     = 10'h122;
  localparam logic [9:0] IDX_FILTER      = 10'h124;
  localparam logic [9:0] IDX_POSITION    = 10'h126;
  localparam logic [9:0] IDX_MAXIMUM     = 10'h128;
  localparam logic [9:0] IDX_IRQ_FLAG    = 10'h130;
  localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h132;
  localparam int         MIN_ADDR_WIDTH  = 11;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_CONTROL  = 16'h0000;
  localparam logic [15:0] RST_FILTER   = 16'h0000;
  localparam logic [15:0] RST_POSITION = 16'h0000;
  localparam logic [15:0] RST_MAXIMUM  = 16'hffff;
  localparam logic [15:0] ALL_ONES     = 16'hffff;
  localparam logic [15:0] ONE          = 16'h0001;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_COUNT_ERROR     = 15;
  localparam int CTL_IDLE_STOP       = 13;
  localparam int CTL_INDEX_STATE     = 12;
  localparam int CTL_DIRECTION       = 11;
  localparam int CTL_MODE_LSB        = 8;
  localparam int CTL_PHASE_SWAP      = 7;
  localparam int CTL_DIR_PIN_OUT     = 6;
  localparam int CTL_TIMER_GATE      = 5;
  localparam int CTL_PRESCALE_LSB    = 3;
  localparam int CTL_INDEX_RESET     = 2;
  localparam int CTL_TIMER_CLOCK     = 1;
  localparam int CTL_DIR_SOURCE      = 0;

  // ****************************************
  // Filter control fields
  // ****************************************
  localparam int FLT_MATCH_LSB       = 9;
  localparam int FLT_CERR_IRQ_DIS    = 8;
  localparam int FLT_OUTPUT_ENABLE   = 7;
  localparam int FLT_CLOCK_DIV_LSB   = 4;

  // ****************************************
  // Interrupt status and enable fields
  // ****************************************
  localparam int IRQ_BIT             = 0;

  // ****************************************
  // Timer prescaler terminal counts (1:1, 1:8, 1:64, 1:256)
  // ****************************************
  localparam logic [7:0] PRESC_TC_1   = 8'h00;
  localparam logic [7:0] PRESC_TC_8   = 8'h07;
  localparam logic [7:0] PRESC_TC_64  = 8'h3f;
  localparam logic [7:0] PRESC_TC_256 = 8'hff;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [2:0] {
    MODE_OFF       = 3'h0,
    MODE_TIMER     = 3'h1,
    MODE_X2_INDEX  = 3'h4,
    MODE_X2_MATCH  = 3'h5,
    MODE_X4_INDEX  = 3'h6,
    MODE_X4_MATCH  = 3'h7
  } encoder_mode_type;

  // Decoded encoder pins after synchronisation
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
    logic a_edge;
    logic b_edge;
    logic a_rise;
    logic a_fall;
    logic up;
    logic index_pulse;
  } qdec_out_type;

endpackage

// File: hdl/quad_decoder.sv
// Pin synchroniser and quadrature edge, direction and index decoder
`timescale 1ns/100ps
module quad_decoder (
  // System
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Encoder pins
  input  wire logic                    phase_a_i,
  input  wire logic                    phase_b_i,
  input  wire logic                    index_i,
  // Control
  input  wire logic                    phase_swap_i,
  // Decoded
  output encoder_pkg::qdec_out_type    dec_o
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] prev_r;

  // ****************************************
  // Two-flop synchroniser, then one stage of history for edges
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
    end else begin
      sync1_r <= {index_i, phase_b_i, phase_a_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Swapping after the synchroniser keeps both channels equally delayed
  wire logic a_cur  = phase_swap_i ? sync2_r[1] : sync2_r[0];
  wire logic b_cur  = phase_swap_i ? sync2_r[0] : sync2_r[1];
  wire logic a_prev = phase_swap_i ? prev_r[1] : prev_r[0];
  wire logic b_prev = phase_swap_i ? prev_r[0] : prev_r[1];

  assign dec_o.a           = a_cur;
  assign dec_o.b           = b_cur;
  assign dec_o.idx         = sync2_r[2];
  assign dec_o.a_edge      = a_cur ^ a_prev;
  assign dec_o.b_edge      = b_cur ^ b_prev;
  assign dec_o.a_rise      = a_cur & ~a_prev;
  assign dec_o.a_fall      = ~a_cur & a_prev;
  // A leading B counts up
  assign dec_o.up          = ~(a_prev ^ b_cur);
  // Index qualifies only while both phases are low
  assign dec_o.index_pulse = sync2_r[2] & ~prev_r[2] & ~a_cur & ~b_cur;

endmodule

// File: test/encoder_interrupt_regs_sva.sv
// Port-level assertions for the encoder interrupt and register block
`timescale 1ns/100ps
module encoder_interrupt_regs_sva #(
  parameter int ADDR_WIDTH = 12
) (
  // System
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // Wishbone
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0]            sel_i,
  input wire logic [31:0]           dat_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  // Pins
  input wire logic                  phase_a_i,
  input wire logic                  phase_b_i,
  input wire logic                  index_i,
  input wire logic                  dir_pin_o,
  input wire logic                  dir_pin_en_o,
  input wire logic                  irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [ADDR_WIDTH-3:0] idx     = adr_i[ADDR_WIDTH-1:2];
  wire                  req     = cyc_i && stb_i;
  wire                  wr0     = ack_o && we_i && sel_i[0];
  wire                  wr_flag = wr0 && idx == encoder_pkg::IDX_IRQ_FLAG;
  wire                  wr_en   = wr0 && idx == encoder_pkg::IDX_IRQ_ENABLE;
  wire                  wr_ctl  = wr0 && idx == encoder_pkg::IDX_CONTROL;
  wire                  mapped  = idx inside {encoder_pkg::IDX_CONTROL, encoder_pkg::IDX_FILTER,
    encoder_pkg::IDX_POSITION, encoder_pkg::IDX_MAXIMUM, encoder_pkg::IDX_IRQ_FLAG,
    encoder_pkg::IDX_IRQ_ENABLE};
  sequence s_take;
    req && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_timely: assert property (s_take |=> s_answer) else $error("late or long ack");
  a_ack_cause: assert property (ack_o |-> $past(req)) else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !ack_o && !irq_o && !dir_pin_o && !dir_pin_en_o) else $error("output active in reset");
  a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (ack_o && !we_i && !mapped |-> dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  // Only a flag or enable write may drop the request; the level lags one cycle
  a_flag_sticky: assert property (irq_o && !wr_flag && !wr_en && !$past(wr_flag)
    && !$past(wr_en) |=> irq_o) else $error("request dropped without software");
  a_enable_gates: assert property (wr_en && !dat_i[0] |=> ##1 !irq_o)
    else $error("request while disabled");
  a_dir_pin_follow: assert property (wr_ctl |=> ##1 dir_pin_en_o == $past(dat_i[6], 2))
    else $error("pin enable does not follow control");
  a_dir_pin_cause: assert property ($changed(dir_pin_en_o) |-> $past(wr_ctl, 2))
    else $error("pin enable changed without write");
endmodule
bind encoder_interrupt_regs encoder_interrupt_regs_sva #(.ADDR_WIDTH(ADDR_WIDTH))
  i_encoder_interrupt_regs_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .phase_a_i(phase_a_i),
  .phase_b_i(phase_b_i), .index_i(index_i), .dir_pin_o(dir_pin_o),
  .dir_pin_en_o(dir_pin_en_o), .irq_o(irq_o));

// File: test/shaft_encoder_model.sv
// Behavioural quadrature encoder on the motor shaft
`timescale 1ns/100ps
module shaft_encoder_model (
  // System
  input  wire logic clk_i,
  // Motion commands, at most one step per clock
  input  wire logic step_i,
  input  wire logic up_i,
  input  wire logic mark_i,
  // Encoder pins
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  logic [1:0] pos_r = 2'h0;
  always_ff @(posedge clk_i) begin
    if (step_i) begin
      pos_r <= up_i ? pos_r + 2'h1 : pos_r - 2'h1;
    end
  end
  // Gray order 00,10,11,01 makes A lead B when turning up
  assign phase_a_o = pos_r[1] ^ pos_r[0];
  assign phase_b_o = pos_r[1];
  // Index only shows with both phases low
  assign index_o   = mark_i && pos_r == 2'h0;
endmodule

// File: test/test_encoder_interrupt_regs.sv
// Self-checking bench for the encoder interrupt and register block
`timescale 1ns/100ps
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module test_encoder_interrupt_regs;
  localparam logic [9:0] CTL = encoder_pkg::IDX_CONTROL;
  localparam logic [9:0] FLT = encoder_pkg::IDX_FILTER;
  localparam logic [9:0] POS = encoder_pkg::IDX_POSITION;
  localparam logic [9:0] MAX = encoder_pkg::IDX_MAXIMUM;
  localparam logic [9:0] FLG = encoder_pkg::IDX_IRQ_FLAG;
  localparam logic [9:0] ENA = encoder_pkg::IDX_IRQ_ENABLE;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o, q;
  logic        ack_o, dir_pin_o, dir_pin_en_o, irq_o, pa, pb, pi;
  logic        step = 1'b0, up = 1'b0, mark = 1'b0;
  logic [15:0] v, w;
  logic [9:0]  ix;
  logic [1:0]  s;
  int          failures = 0;
  int          compares = 0;
  initial forever #25 clk_i = ~clk_i;
  encoder_interrupt_regs i_encoder_interrupt_regs (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .phase_a_i(pa), .phase_b_i(pb), .index_i(pi),
    .dir_pin_o(dir_pin_o), .dir_pin_en_o(dir_pin_en_o), .irq_o(irq_o));
  shaft_encoder_model i_shaft_encoder_model (.clk_i(clk_i), .step_i(step), .up_i(up),
    .mark_i(mark), .phase_a_o(pa), .phase_b_o(pb), .index_o(pi));
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Classic cycle; request held until ack is sampled, then released for a cycle
  task automatic bus(input logic wr, input logic [9:0] i, input logic [15:0] d,
                     input logic [3:0] sl);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {i, 2'b00};
    sel_i <= sl;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    bus(1'b1, i, d, 4'h3);
  endtask
  task automatic rd_chk(input logic [9:0] i, input logic [15:0] e, input logic [15:0] m);
    bus(1'b0, i, 16'h0000, 4'h3);
    `CHK(q & {16'hffff, m}, {16'h0000, e & m})
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq_o !== e && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(irq_o, e)
    if (n >= 30) begin
      wrap_up();
    end
  endtask
  task automatic turn(input logic u);
    @(posedge clk_i);
    step <= 1'b1;
    up   <= u;
    @(posedge clk_i);
    step <= 1'b0;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                        input logic [1:0] sl);
    merge = {sl[1] ? n[15:8] : o[15:8], sl[0] ? n[7:0] : o[7:0]};
  endfunction
  initial begin
    void'($urandom(27));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(CTL, 16'h0000, 16'hffff);
    rd_chk(MAX, 16'hffff, 16'hffff);
    wr(10'h3ff, 16'hffff);
    rd_chk(10'h3ff, 16'h0000, 16'hffff);
    wr(FLT, 16'hffff);
    rd_chk(FLT, 16'h07f0, 16'hffff);
    wr(CTL, 16'h60ff);
    rd_chk(CTL, 16'h20ff, 16'he7ff);
    `CHK(dir_pin_en_o, 1'b1)
    wr(FLT, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      ix = i[0] ? MAX : POS;
      v  = 16'($urandom);
      s  = 2'($urandom);
      bus(1'b0, ix, 16'h0000, 4'h3);
      w  = merge(q[15:0], v, s);
      bus(1'b1, ix, v, {2'b00, s});
      rd_chk(ix, w, 16'hffff);
    end
    // Match mode: wrap up past maximum, then underflow
    wr(CTL, 16'h0700);
    wr(MAX, 16'h0003);
    wr(POS, 16'h0003);
    wr(FLG, 16'h0000);
    wr(ENA, 16'h0001);
    turn(1'b1);
    wait_irq(1'b1);
    rd_chk(POS, 16'h0000, 16'hffff);
    wr(ENA, 16'h0000);
    wait_irq(1'b0);
    rd_chk(FLG, 16'h0001, 16'hffff);
    wr(ENA, 16'h0001);
    wait_irq(1'b1);
    wr(FLG, 16'h0000);
    wait_irq(1'b0);
    wr(CTL, 16'h0500);
    turn(1'b0);
    wait_irq(1'b1);
    rd_chk(POS, 16'h0003, 16'hffff);
    // Index with counter reset
    wr(CTL, 16'h0604);
    wr(POS, 16'h0042);
    wr(FLG, 16'h0000);
    mark <= 1'b1;
    repeat (2) @(posedge clk_i);
    mark <= 1'b0;
    wait_irq(1'b1);
    rd_chk(POS, 16'h0000, 16'hffff);
    // Count error at maximum plus one, then with its event disabled
    wr(CTL, 16'h0600);
    wr(MAX, 16'h0005);
    wr(POS, 16'h0005);
    wr(FLG, 16'h0000);
    turn(1'b1);
    wait_irq(1'b1);
    rd_chk(CTL, 16'h8600, 16'hc7ff);
    `CHK(dir_pin_o, 1'b1)
    wr(CTL, 16'h0600);
    wr(FLT, 16'h0100);
    wr(POS, 16'h0005);
    wr(FLG, 16'h0000);
    turn(1'b1);
    repeat (8) @(posedge clk_i);
    rd_chk(FLG, 16'h0000, 16'hffff);
    rd_chk(CTL, 16'h8600, 16'hc7ff);
    // Timer period match counting up, then down
    wr(FLT, 16'h0000);
    wr(MAX, 16'h0fff);
    wr(POS, 16'h0000);
    wr(CTL, 16'h0100);
    wr(CTL, 16'h0900);
    wr(FLG, 16'h0000);
    rd_chk(FLG, 16'h0000, 16'hffff);
    wr(POS, 16'h0ffc);
    wait_irq(1'b1);
    wr(POS, 16'h0400);
    wr(CTL, 16'h0100);
    wr(FLG, 16'h0000);
    rd_chk(FLG, 16'h0000, 16'hffff);
    wr(POS, 16'h0003);
    wait_irq(1'b1);
    // Gated accumulation ends on falling phase A; the flag clear lands on that same edge
    wr(CTL, 16'h0120);
    wr(FLG, 16'h0000);
    rd_chk(FLG, 16'h0000, 16'hffff);
    turn(1'b1);
    wr(FLG, 16'h0000);
    wait_irq(1'b1);
    rd_chk(FLG, 16'h0001, 16'hffff);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(irq_o, 1'b0)
    rd_chk(CTL, 16'h0000, 16'hffff);
    wrap_up();
  end
endmodule
